// >>> hdl/usfc_pkg.sv
// constants and types shared by the uart status and frame control block
// assumes one 50 mhz clock and an axi4-lite register port
package usfc_pkg;
  localparam logic [7:0] OFS_STATUS = 8'h00;
  localparam logic [7:0] OFS_FRAME = 8'h04;
  localparam logic [7:0] OFS_CTRL = 8'h08;
  localparam logic [7:0] OFS_DATA = 8'h0c;
  localparam logic [7:0] OFS_BAUD = 8'h10;
  localparam logic [7:0] OFS_WIRE = 8'h14;
  localparam logic [7:0] OFS_COUNT = 8'h18;
  localparam logic [7:0] STATUS_RESET = 8'h0b;
  localparam logic [15:0] BAUD_RESET = 16'h01b2;
  localparam logic [4:0] BREAK_BITS = 5'h0d;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    PAR_EVEN = 2'b00, PAR_ODD = 2'b01, PAR_MARK = 2'b10, PAR_SPACE = 2'b11
  } usfc_parity_type;

  typedef struct packed {
    logic global_serial_enable;
    logic word_length_select;
    logic parity_enable;
    usfc_parity_type parity_type_field;
    logic break_control;
    logic received_ninth_bit;
    logic transmit_ninth_bit;
  } usfc_frame_type;

  typedef struct packed {
    logic transmitter_enable;
    logic receiver_enable;
    logic two_stop;
    logic addr_detect;
    logic wake;
    logic receive_interrupt_enable;
    logic idle_interrupt_enable;
    logic empty_interrupt_enable;
  } usfc_ctrl_type;

  typedef struct packed {
    logic [8:0] bits;
    logic framing;
    logic noise;
  } usfc_rx_word_type;

  typedef enum logic [2:0] {
    LN_IDLE = 3'b000, LN_START = 3'b001, LN_DATA = 3'b010,
    LN_STOP = 3'b011, LN_BREAK = 3'b100
  } usfc_line_type;
endpackage : usfc_pkg

// >>> hdl/usfc_receiver.sv
// serial receiver: majority of three samples at each bit centre
// assumes the divisor is at least 4 and is steady during a frame
`timescale 1ns/10ps
module usfc_receiver import usfc_pkg::*; #(
  parameter int DIV_W = 16
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic ce,
  input wire logic en,
  input wire logic rxd,
  input wire logic [DIV_W-1:0] divisor,
  input wire logic nine,
  output usfc_rx_word_type word,
  output logic done,
  output logic busy
);
  usfc_line_type state_q;
  logic [DIV_W-1:0] cnt_q;
  logic [3:0] bit_q;
  logic [2:0] smp_q;
  logic noise_q;
  logic maj;
  logic mid;
  logic last;

  assign maj = (smp_q[0] & smp_q[1]) | (smp_q[1] & smp_q[2]) | (smp_q[0] & smp_q[2]);
  assign mid = cnt_q == (divisor >> 1);
  assign last = cnt_q == divisor - 1'b1;
  assign busy = state_q != LN_IDLE;

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      smp_q <= 3'h7;
    end else if (ce) begin
      smp_q <= {smp_q[1:0], rxd};
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      state_q <= LN_IDLE;
      cnt_q <= '0;
      bit_q <= 4'h0;
      noise_q <= 1'b0;
      word <= '0;
      done <= 1'b0;
    end else if (ce) begin
      done <= 1'b0;
      cnt_q <= last ? '0 : cnt_q + 1'b1;
      if (!en) begin
        state_q <= LN_IDLE;
        cnt_q <= '0;
      end else begin
        case (state_q)
          LN_IDLE: begin
            cnt_q <= '0;
            noise_q <= 1'b0;
            bit_q <= 4'h0;
            if (!rxd) begin
              state_q <= LN_START;
            end
          end
          LN_START: begin
            if (mid) begin
              noise_q <= smp_q != 3'h0 && smp_q != 3'h7;
              if (maj) begin
                state_q <= LN_IDLE;
              end
            end
            if (last) begin
              state_q <= LN_DATA;
            end
          end
          LN_DATA: begin
            if (mid) begin
              word.bits[bit_q] <= maj;
              noise_q <= noise_q | (smp_q != 3'h0 && smp_q != 3'h7);
            end
            if (last) begin
              bit_q <= bit_q + 4'h1;
              if (bit_q == (nine ? 4'h8 : 4'h7)) begin
                state_q <= LN_STOP;
              end
            end
          end
          default: begin
            if (mid) begin
              word.framing <= !maj;
              word.noise <= noise_q | (smp_q != 3'h0 && smp_q != 3'h7);
              if (!nine) begin
                word.bits[8] <= 1'b0;
              end
            end
            if (last) begin
              done <= 1'b1;
              state_q <= LN_IDLE;
            end
          end
        endcase
      end
    end
  end
endmodule : usfc_receiver

// >>> hdl/usfc_top.sv
// uart status flags and frame control with an axi4-lite register port
// assumes serial inputs synchronous to clk; pad drivers resolve the enables
`timescale 1ns/10ps
module usfc_top import usfc_pkg::*; #(
  parameter int DIV_W = 16,
  parameter logic [15:0] BAUD_INIT = BAUD_RESET
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic ce,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic tx_out,
  output logic tx_oe,
  input wire logic rxtx_in,
  output logic rxtx_out,
  output logic rxtx_oe,
  output logic irq
);
  generate
    if (DIV_W < 4 || DIV_W > 16) begin : g_bad_width
      $error("usfc_top: DIV_W must be 4 to 16");
    end
  endgenerate

  function automatic logic par_bit(input logic [8:0] w, input logic nine,
                                   input usfc_parity_type t);
    logic x;
    x = nine ? ^w[7:0] : ^w[6:0];
    case (t)
      PAR_EVEN: par_bit = x;
      PAR_ODD: par_bit = !x;
      PAR_MARK: par_bit = 1'b1;
      default: par_bit = 1'b0;
    endcase
  endfunction : par_bit

  function automatic logic [2:0] decode(input logic [7:0] a);
    if (a == OFS_STATUS) decode = 3'd0;
    else if (a == OFS_FRAME) decode = 3'd1;
    else if (a == OFS_CTRL) decode = 3'd2;
    else if (a == OFS_DATA) decode = 3'd3;
    else if (a == OFS_BAUD) decode = 3'd4;
    else if (a == OFS_WIRE) decode = 3'd5;
    else if (a == OFS_COUNT) decode = 3'd6;
    else decode = 3'd7;
  endfunction : decode

  ////////////////////////////////////////////////////////////////
  // state

  usfc_frame_type frame_q;
  usfc_ctrl_type ctrl_q;
  logic single_wire_select_q;
  logic [DIV_W-1:0] baud_q;
  logic [7:0] rx_data_q;
  logic [8:0] tx_hold_q;
  logic tx_full_q;
  logic parity_error_flag_q, nf_q, framing_error_flag_q, overrun_flag_q, receive_available_flag_q, transmitter_idle_flag_q;
  logic [4:0] arm_q;
  logic [7:0] awaddr_q;
  logic [31:0] wdata_q;
  logic wr_go, rd_go;
  logic [2:0] wsel, rsel;
  logic gen, tx_act, rx_act, wire_tx;
  logic [7:0] status;
  usfc_rx_word_type rx_word;
  logic rx_done, rx_busy, tx_take, tx_busy, txd;
  logic [8:0] tx_word;
  logic rx_store, rx_parity_error_flag;
  logic data_rd, data_wr, stat_rd;

  assign gen = frame_q.global_serial_enable;
  assign tx_act = gen & ctrl_q.transmitter_enable;
  assign rx_act = gen & ctrl_q.receiver_enable;
  // receiver enable takes the shared pin when both are set
  assign wire_tx = single_wire_select_q & !ctrl_q.receiver_enable;
  assign status = {parity_error_flag_q, nf_q, framing_error_flag_q, overrun_flag_q, !rx_busy, receive_available_flag_q, transmitter_idle_flag_q,
                   !tx_full_q};
  assign wr_go = !s_axi_awready & !s_axi_wready & !s_axi_bvalid;
  assign rd_go = s_axi_arvalid & s_axi_arready;
  assign wsel = decode(awaddr_q);
  assign rsel = decode(s_axi_araddr);
  assign stat_rd = rd_go && rsel == 3'd0;
  assign data_rd = rd_go && rsel == 3'd3;
  assign data_wr = wr_go && wsel == 3'd3;

  ////////////////////////////////////////////////////////////////
  // axi4-lite handshakes

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
      awaddr_q <= 8'h00;
      wdata_q <= 32'h0000_0000;
    end else if (ce) begin
      if (s_axi_awvalid && s_axi_awready) begin
        s_axi_awready <= 1'b0;
        awaddr_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        s_axi_wready <= 1'b0;
        wdata_q <= s_axi_wdata;
      end
      if (wr_go) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wsel == 3'd7 ? RESP_SLVERR : RESP_OKAY;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= RESP_OKAY;
    end else if (ce) begin
      if (rd_go) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= RESP_OKAY;
        if (rsel == 3'd0) begin
          s_axi_rdata <= {24'h0, status};
        end else if (rsel == 3'd1) begin
          // transmit ninth bit reads back as zero
          s_axi_rdata <= {24'h0, frame_q[7:1], 1'b0};
        end else if (rsel == 3'd2) begin
          s_axi_rdata <= {24'h0, ctrl_q};
        end else if (rsel == 3'd3) begin
          s_axi_rdata <= {24'h0, rx_data_q};
        end else if (rsel == 3'd4) begin
          s_axi_rdata <= {{(32 - DIV_W){1'b0}}, baud_q};
        end else if (rsel == 3'd5) begin
          s_axi_rdata <= {31'h0, single_wire_select_q};
        end else if (rsel == 3'd6) begin
          s_axi_rdata <= {31'h0, receive_available_flag_q};
        end else begin
          s_axi_rdata <= 32'h0000_0000;
          s_axi_rresp <= RESP_SLVERR;
        end
      end
      if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////
  // configuration registers

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      frame_q <= '0;
      ctrl_q <= '0;
      single_wire_select_q <= 1'b0;
      baud_q <= BAUD_INIT[DIV_W-1:0];
    end else if (ce) begin
      if (wr_go && s_axi_wstrb[0]) begin
        if (wsel == 3'd1) begin
          frame_q.global_serial_enable <= wdata_q[7];
          frame_q.word_length_select <= wdata_q[6];
          frame_q.parity_enable <= wdata_q[5];
          frame_q.parity_type_field <= usfc_parity_type'(wdata_q[4:3]);
          frame_q.break_control <= wdata_q[2];
          frame_q.transmit_ninth_bit <= wdata_q[0];
        end else if (wsel == 3'd2) begin
          ctrl_q <= wdata_q[7:0];
        end else if (wsel == 3'd4) begin
          baud_q <= wdata_q[DIV_W-1:0];
        end else if (wsel == 3'd5) begin
          single_wire_select_q <= wdata_q[0];
        end
      end
      if (rx_store && frame_q.word_length_select && !frame_q.parity_enable) begin
        frame_q.received_ninth_bit <= rx_word.bits[8];
      end
      // other configuration survives a disable untouched
      if (!gen) begin
        ctrl_q.transmitter_enable <= 1'b0;
        ctrl_q.receiver_enable <= 1'b0;
        frame_q.break_control <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////
  // receive path and flags

  assign rx_parity_error_flag = frame_q.parity_enable &&
    (frame_q.word_length_select ? rx_word.bits[8] : rx_word.bits[7]) !=
    par_bit(rx_word.bits, frame_q.word_length_select, frame_q.parity_type_field);
  // one-word buffer: a second word while full is an overrun
  assign rx_store = rx_done && rx_act && !receive_available_flag_q && !overrun_flag_q;

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      rx_data_q <= 8'h00;
    end else if (ce && rx_store) begin
      rx_data_q <= {rx_word.bits[7] & !(frame_q.parity_enable &&
                    !frame_q.word_length_select), rx_word.bits[6:0]};
    end
  end

  // arm bits: parity_error_flag/nf/framing_error_flag, overrun, available, idle, empty seen at status read
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      arm_q <= 5'h00;
    end else if (ce) begin
      if (!gen) begin
        arm_q <= 5'h00;
      end else if (stat_rd) begin
        arm_q <= {parity_error_flag_q | nf_q | framing_error_flag_q, overrun_flag_q, receive_available_flag_q, transmitter_idle_flag_q, !tx_full_q};
      end else if (data_rd || data_wr) begin
        arm_q <= 5'h00;
      end
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      parity_error_flag_q <= 1'b0;
      nf_q <= 1'b0;
      framing_error_flag_q <= 1'b0;
      overrun_flag_q <= 1'b0;
      receive_available_flag_q <= 1'b0;
    end else if (ce) begin
      if (!gen) begin
        {parity_error_flag_q, nf_q, framing_error_flag_q, overrun_flag_q, receive_available_flag_q} <= 5'h00;
      end else begin
        if ((data_rd || data_wr) && arm_q[4]) begin
          {parity_error_flag_q, nf_q, framing_error_flag_q} <= 3'h0;
        end
        if ((data_rd || data_wr) && arm_q[3]) begin
          overrun_flag_q <= 1'b0;
        end
        if (data_rd && arm_q[2]) begin
          receive_available_flag_q <= 1'b0;
        end
        // a word ending in the clearing cycle is not stored; it sets overrun instead
        if (rx_store) begin
          receive_available_flag_q <= 1'b1;
          parity_error_flag_q <= rx_parity_error_flag;
          nf_q <= rx_word.noise;
          framing_error_flag_q <= rx_word.framing;
        end
        if (rx_done && rx_act && receive_available_flag_q) begin
          overrun_flag_q <= 1'b1;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////
  // transmit path and flags

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      tx_hold_q <= 9'h000;
      tx_full_q <= 1'b0;
    end else if (ce) begin
      if (!tx_act) begin
        tx_full_q <= 1'b0;
      end else if (data_wr) begin
        tx_full_q <= 1'b1;
        tx_hold_q <= {frame_q.transmit_ninth_bit, wdata_q[7:0]};
        if (frame_q.parity_enable && frame_q.word_length_select) begin
          tx_hold_q[8] <= par_bit({1'b0, wdata_q[7:0]}, 1'b1,
                                  frame_q.parity_type_field);
        end else if (frame_q.parity_enable) begin
          tx_hold_q[7] <= par_bit({1'b0, wdata_q[7:0]}, 1'b0,
                                  frame_q.parity_type_field);
        end
      end else if (tx_take) begin
        tx_full_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      transmitter_idle_flag_q <= 1'b1;
    end else if (ce) begin
      if (!gen) begin
        transmitter_idle_flag_q <= 1'b1;
      end else if (data_wr && arm_q[1]) begin
        transmitter_idle_flag_q <= 1'b0;
      end else begin
        transmitter_idle_flag_q <= !tx_full_q && !tx_busy && !frame_q.break_control;
      end
    end
  end

  assign tx_word = tx_hold_q;

  ////////////////////////////////////////////////////////////////
  // pins and interrupt request

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      tx_out <= 1'b1;
      tx_oe <= 1'b0;
      rxtx_out <= 1'b1;
      rxtx_oe <= 1'b0;
      irq <= 1'b0;
    end else if (ce) begin
      tx_out <= txd;
      tx_oe <= tx_act;
      rxtx_out <= txd;
      rxtx_oe <= tx_act && wire_tx;
      irq <= (ctrl_q.receive_interrupt_enable && (overrun_flag_q || receive_available_flag_q)) ||
             (ctrl_q.idle_interrupt_enable && transmitter_idle_flag_q) ||
             (ctrl_q.empty_interrupt_enable && !tx_full_q);
    end
  end

  usfc_receiver #(.DIV_W(DIV_W)) u_rx (
    .clk(clk),
    .reset(reset),
    .ce(ce),
    .en(rx_act && !rxtx_oe),
    .rxd(rxtx_in),
    .divisor(baud_q),
    .nine(frame_q.word_length_select),
    .word(rx_word),
    .done(rx_done),
    .busy(rx_busy)
  );

  usfc_transmitter #(.DIV_W(DIV_W)) u_tx (
    .clk(clk),
    .reset(reset),
    .ce(ce),
    .en(tx_act),
    .pending(tx_full_q),
    .data(tx_word),
    .nine(frame_q.word_length_select),
    .two_stop(ctrl_q.two_stop),
    .brk(frame_q.break_control),
    .divisor(baud_q),
    .take(tx_take),
    .txd(txd),
    .busy(tx_busy)
  );
endmodule : usfc_top

// >>> hdl/usfc_transmitter.sv
// serial transmitter with break generation
// assumes the holding register pending flag stays until take
`timescale 1ns/10ps
module usfc_transmitter import usfc_pkg::*; #(
  parameter int DIV_W = 16
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic ce,
  input wire logic en,
  input wire logic pending,
  input wire logic [8:0] data,
  input wire logic nine,
  input wire logic two_stop,
  input wire logic brk,
  input wire logic [DIV_W-1:0] divisor,
  output logic take,
  output logic txd,
  output logic busy
);
  usfc_line_type state_q;
  logic [DIV_W-1:0] cnt_q;
  logic [4:0] bit_q;
  logic [8:0] sh_q;
  logic last;

  assign last = cnt_q == divisor - 1'b1;
  assign busy = state_q != LN_IDLE;

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      state_q <= LN_IDLE;
      cnt_q <= '0;
      bit_q <= 5'h0;
      sh_q <= 9'h1ff;
      take <= 1'b0;
      txd <= 1'b1;
    end else if (ce) begin
      take <= 1'b0;
      cnt_q <= last ? '0 : cnt_q + 1'b1;
      if (!en) begin
        state_q <= LN_IDLE;
        txd <= 1'b1;
        cnt_q <= '0;
      end else begin
        case (state_q)
          LN_IDLE: begin
            cnt_q <= '0;
            bit_q <= 5'h0;
            txd <= 1'b1;
            if (pending) begin
              take <= 1'b1;
              sh_q <= data;
              txd <= 1'b0;
              state_q <= LN_START;
            end else if (brk) begin
              txd <= 1'b0;
              state_q <= LN_BREAK;
            end
          end
          LN_START: begin
            if (last) begin
              txd <= sh_q[0];
              sh_q <= {1'b1, sh_q[8:1]};
              state_q <= LN_DATA;
            end
          end
          LN_DATA: begin
            if (last) begin
              bit_q <= bit_q + 5'h1;
              txd <= sh_q[0];
              sh_q <= {1'b1, sh_q[8:1]};
              if (bit_q == (nine ? 5'h8 : 5'h7)) begin
                txd <= 1'b1;
                bit_q <= 5'h0;
                state_q <= LN_STOP;
              end
            end
          end
          LN_STOP: begin
            if (last) begin
              bit_q <= bit_q + 5'h1;
              if (bit_q == {4'h0, two_stop}) begin
                state_q <= LN_IDLE;
              end
            end
          end
          default: begin
            txd <= 1'b0;
            if (last && bit_q != BREAK_BITS) begin
              bit_q <= bit_q + 5'h1;
            end
            if (bit_q == BREAK_BITS && !brk) begin
              txd <= 1'b1;
              state_q <= LN_IDLE;
            end
          end
        endcase
      end
    end
  end
endmodule : usfc_transmitter

// >>> verification/uart_status_and_frame_control_tb_top.sv
// bench: register tests over axi4-lite with a serial partner
// assumes BAUD_INIT of 8 cycles per bit
`timescale 1ns/10ps
`define CHK(a, e) begin num_checks++; if ((a) !== (e)) begin miscompares++; \
  $display("Error at %0t got %h expected %h", $time, a, e); end end
module uart_status_and_frame_control_tb_top;
  import usfc_pkg::*;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0, rdata, v;
  logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic awready, wready, bvalid, arready, rvalid, tx_out, tx_oe, rxtx_in, rxtx_out;
  logic rxtx_oe, irq, p;
  logic [1:0] bresp, rresp, r;
  logic [9:0] q;
  int miscompares = 0;
  int num_checks = 0;
  usfc_top #(.BAUD_INIT(16'h0008)) dut_u (.clk(clk), .reset(reset), .ce(1'b1),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .tx_out(tx_out), .tx_oe(tx_oe), .rxtx_in(rxtx_in), .rxtx_out(rxtx_out),
    .rxtx_oe(rxtx_oe), .irq(irq));
  // a released transmit pin floats up to its pull-up level
  usfc_serial_partner #(.DIV(8)) peer_u (.clk(clk), .tx(tx_oe ? tx_out : 1'b1),
    .line(rxtx_in));
  initial begin
    forever #10 clk = ~clk;
  end
  ////////////////////////////////////////
  task wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge clk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid);
    r = bresp;
    bready <= 1'b0;
  endtask : wr
  task rd(input logic [7:0] a);
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge clk);
      if (arready) arvalid <= 1'b0;
    end while (!rvalid);
    v = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask : rd
  task chk(input logic [7:0] a, input logic [7:0] e);
    rd(a);
    `CHK(v, {24'h0, e})
  endtask : chk
  task stop_test;
    $display("checks %0d miscompares %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : stop_test
  initial begin
    repeat (10000) @(posedge clk);
    miscompares++;
    stop_test;
  end
  ////////////////////////////////////////
  initial begin
    repeat (16) @(posedge clk);
    reset <= 1'b0;
    chk(OFS_STATUS, 8'h0b);
    wr(OFS_STATUS, 32'h0);
    `CHK(r, RESP_OKAY)
    chk(OFS_STATUS, 8'h0b);
    rd(8'h40);
    `CHK(r, RESP_SLVERR)
    wr(8'h40, 32'h0);
    `CHK(r, RESP_SLVERR)
    wr(OFS_FRAME, 32'h80);
    wr(OFS_CTRL, 32'hc1);
    chk(OFS_STATUS, 8'h0b);
    `CHK(irq, 1'b1)
    peer_u.send(10'h0a5, 8, 1'b1);
    chk(OFS_STATUS, 8'h0f);
    chk(OFS_COUNT, 8'h01);
    chk(OFS_DATA, 8'ha5);
    chk(OFS_STATUS, 8'h0b);
    peer_u.send(10'h03c, 8, 1'b0);
    chk(OFS_STATUS, 8'h2f);
    chk(OFS_DATA, 8'h3c);
    chk(OFS_STATUS, 8'h0b);
    peer_u.send(10'h011, 8, 1'b1);
    peer_u.send(10'h022, 8, 1'b1);
    chk(OFS_STATUS, 8'h1f);
    chk(OFS_DATA, 8'h11);
    chk(OFS_STATUS, 8'h0b);
    for (int t = 0; t < 4; t++) begin
      wr(OFS_FRAME, 32'ha0 | (32'(t) << 3));
      p = (t == 0) ? ^7'h35 : (t == 1) ? ~^7'h35 : (t == 2);
      peer_u.send({2'b00, ~p, 7'h35}, 8, 1'b1);
      chk(OFS_STATUS, 8'h8f);
      chk(OFS_DATA, 8'h35);
    end
    wr(OFS_FRAME, 32'hc0);
    peer_u.send(10'h1a5, 9, 1'b1);
    chk(OFS_STATUS, 8'h0f);
    chk(OFS_FRAME, 8'hc2);
    chk(OFS_DATA, 8'ha5);
    wr(OFS_FRAME, 32'h80);
    chk(OFS_STATUS, 8'h0b);
    wr(OFS_DATA, 32'h5a);
    rd(OFS_STATUS);
    `CHK(v[1], 1'b0)
    peer_u.recv(q, 8);
    `CHK(q[7:0], 8'h5a)
    chk(OFS_STATUS, 8'h0b);
    // 13 bit times at 8 cycles is 104; wait beyond it
    wr(OFS_FRAME, 32'h84);
    repeat (150) @(posedge clk);
    `CHK(tx_out, 1'b0)
    wr(OFS_FRAME, 32'h80);
    repeat (20) @(posedge clk);
    `CHK(tx_out, 1'b1)
    // break cleared early still lasts 13 bit times
    wr(OFS_FRAME, 32'h84);
    wr(OFS_FRAME, 32'h80);
    repeat (60) @(posedge clk);
    `CHK(tx_out, 1'b0)
    repeat (60) @(posedge clk);
    `CHK(tx_out, 1'b1)
    wr(OFS_WIRE, 32'h1);
    wr(OFS_CTRL, 32'h81);
    chk(OFS_WIRE, 8'h01);
    `CHK({rxtx_oe, tx_oe, rxtx_out}, 3'h7)
    wr(OFS_WIRE, 32'h0);
    wr(OFS_CTRL, 32'hc7);
    fork
      peer_u.send(10'h055, 8, 1'b1);
      begin
        repeat (40) @(posedge clk);
        chk(OFS_STATUS, 8'h03);
      end
    join
    `CHK(irq, 1'b1)
    wr(OFS_FRAME, 32'h00);
    chk(OFS_CTRL, 8'h07);
    chk(OFS_STATUS, 8'h0b);
    chk(OFS_COUNT, 8'h00);
    chk(OFS_BAUD, 8'h08);
    `CHK(tx_oe, 1'b0)
    `CHK(rxtx_oe, 1'b0)
    stop_test;
  end
endmodule : uart_status_and_frame_control_tb_top

// >>> verification/usfc_assertions.sv
// checker: bus handshake and pin enable properties of usfc_top
// assumes binding to usfc_top, one clock domain
`timescale 1ns/10ps
module usfc_assertions (
  input wire logic clk,
  input wire logic reset,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic tx_oe,
  input wire logic rxtx_oe
);
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read not answered");
  a_rdata_stands: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data dropped");
  a_bvalid_stands: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write response dropped");
  a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid &&
    s_axi_wready |-> ##[1:2] s_axi_bvalid) else $error("write not answered");
  a_read_refuse: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken while busy");
  a_write_refuse: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken while busy");
  a_resp_release: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("write response repeated");
  a_shared_pin: assert property (rxtx_oe |-> tx_oe)
    else $error("shared pin driven without transmitter");
endmodule : usfc_assertions
////////////////////////////////////////
bind usfc_top usfc_assertions chk_u (.clk(clk), .reset(reset),
  .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
  .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
  .s_axi_rdata(s_axi_rdata), .tx_oe(tx_oe), .rxtx_oe(rxtx_oe));

// >>> verification/usfc_serial_partner.sv
// far serial device: sends frames on the receive line, decodes the transmit pin
// assumes DIV clk cycles per bit, agreed with the block's divisor
`timescale 1ns/10ps
module usfc_serial_partner #(
  parameter int DIV = 8
) (
  input wire logic clk,
  input wire logic tx,
  output logic line
);
  initial line = 1'b1;
  ////////////////////////////////////////
  // stop low gives a badly framed character on purpose
  task send(input logic [9:0] d, input int n, input logic stop);
    @(posedge clk);
    line <= 1'b0;
    repeat (DIV) @(posedge clk);
    for (int i = 0; i < n; i++) begin
      line <= d[i];
      repeat (DIV) @(posedge clk);
    end
    line <= stop;
    repeat (DIV) @(posedge clk);
    line <= 1'b1;
    repeat (2 * DIV) @(posedge clk);
  endtask : send
  task recv(output logic [9:0] d, input int n);
    d = 10'h000;
    while (tx) @(posedge clk);
    repeat (DIV / 2) @(posedge clk);
    for (int i = 0; i < n; i++) begin
      repeat (DIV) @(posedge clk);
      d[i] = tx;
    end
    // run past the stop bit so idle is reached
    repeat (2 * DIV) @(posedge clk);
  endtask : recv
endmodule : usfc_serial_partner
